// ---- src/pwm_fault_event_pkg.sv ----
// constants, types and register map of the pwm fault and event block
// Operation
// - unlatched mode: fault status shows live level of each selected trigger
// - latched mode: fault status shows latched triggers, kept after input drops
// - latched trigger stays set until software clears it, only named bits
// - fault status bit one means trigger active, zero means inactive
// - two groups: four external fault inputs, eight comparator triggers
// - each group selection per generator reads back exactly as chosen
// - each generator holds its own independent fault trigger selection
// - after reset or without extended selection, only fault input zero counts
// - trigger selection only takes effect with extended selection enabled
// - generator fault is OR of all selected triggers of both groups
// - each external fault input passes its own sense before combining
// - writing one clears an interrupt status bit, zero leaves it
// - raw status shows all events, masked status is raw AND enables
// - six counter event interrupt enables, cleared enable masks interrupt
// - same register holds six independent trigger output enables
// - min hold mode keeps fault asserted for programmed cycles at least
// - suppressed outputs go low during fault unless drive level high
package pwm_fault_event_pkg;

    localparam int NUM_GEN   = 4;
    localparam int NUM_EXT   = 4;
    localparam int NUM_CMP   = 8;
    localparam int NUM_EVT   = 6;
    localparam int NUM_OUT   = 8;
    localparam int CNT_W     = 16;

    // per generator block stride and register offsets (byte addresses)
    localparam logic [11:0] GEN_STRIDE     = 12'h040;
    localparam logic [5:0]  OFS_MODE       = 6'h00;
    localparam logic [5:0]  OFS_SENSE      = 6'h04;
    localparam logic [5:0]  OFS_MINPER     = 6'h08;
    localparam logic [5:0]  OFS_SEL0       = 6'h0C;
    localparam logic [5:0]  OFS_SEL1       = 6'h10;
    localparam logic [5:0]  OFS_FSTAT0     = 6'h14;
    localparam logic [5:0]  OFS_FSTAT1     = 6'h18;
    localparam logic [5:0]  OFS_INTEN      = 6'h1C;
    localparam logic [5:0]  OFS_RIS        = 6'h20;
    localparam logic [5:0]  OFS_MIS        = 6'h24;
    localparam logic [5:0]  OFS_CMPA       = 6'h28;
    localparam logic [5:0]  OFS_CMPB       = 6'h2C;
    localparam logic [11:0] OFS_SUPPRESS   = 12'h100;
    localparam logic [11:0] OFS_FLT_LEVEL  = 12'h104;

    // mode register fields
    localparam int MODE_LATCH_BIT  = 0;
    localparam int MODE_EXTSRC_BIT = 1;
    localparam int MODE_MINPER_BIT = 2;

    // interrupt/trigger enable register fields
    localparam int INTEN_IRQ_LSB  = 0;
    localparam int INTEN_TRIG_LSB = 8;

    // event bit positions
    localparam int EVT_ZERO = 0;
    localparam int EVT_LOAD = 1;
    localparam int EVT_AU   = 2;
    localparam int EVT_AD   = 3;
    localparam int EVT_BU   = 4;
    localparam int EVT_BD   = 5;

    // reset values
    localparam logic [2:0]       RST_MODE   = 3'h0;
    localparam logic [3:0]       RST_SENSE  = 4'h0;
    localparam logic [CNT_W-1:0] RST_MINPER = 16'h0000;
    localparam logic [3:0]       RST_SEL0   = 4'h0;
    localparam logic [7:0]       RST_SEL1   = 8'h00;
    localparam logic [3:0]       LEGACY_SEL = 4'h1;

    typedef struct packed {
        logic [2:0]       mode;
        logic [3:0]       sense;
        logic [CNT_W-1:0] minper;
        logic [3:0]       sel0;
        logic [7:0]       sel1;
        logic [3:0]       lat0;
        logic [7:0]       lat1;
        logic [CNT_W-1:0] hold;
        logic [5:0]       irq_en;
        logic [5:0]       trig_en;
        logic [5:0]       ris;
        logic [CNT_W-1:0] cmpa;
        logic [CNT_W-1:0] cmpb;
        logic [CNT_W-1:0] prev_cnt;
        logic             fault;
        logic [5:0]       trig;
    } gen_t;

    typedef struct packed {
        gen_t [NUM_GEN-1:0] gen;
        logic [7:0]         supp;
        logic [7:0]         lvl;
        logic [7:0]         pwm;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        logic               irq;
    } state_t;

endpackage : pwm_fault_event_pkg

// ---- src/pwm_fault_event.sv ----
// fault trigger selection, fault status and counter event interrupt logic
`timescale 1ns/10ps
module pwm_fault_event
    import pwm_fault_event_pkg::*;
(
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // apb slave
    input  wire logic [11:0]             paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // fault sources
    input  wire logic [NUM_EXT-1:0]      external_fault_input,
    input  wire logic [NUM_CMP-1:0]      comparator_fault_trigger,
    // counter state per generator
    input  wire logic [NUM_GEN*CNT_W-1:0] cnt_value,
    input  wire logic [NUM_GEN-1:0]      cnt_up,
    input  wire logic [NUM_GEN-1:0]      cnt_load,
    // pwm signals
    input  wire logic [NUM_OUT-1:0]      pwm_in,
    output logic      [NUM_OUT-1:0]      pwm_out,
    // results
    output logic      [NUM_GEN-1:0]      gen_fault,
    output logic      [NUM_GEN*NUM_EVT-1:0] event_trigger,
    output logic                         irq
);

    state_t st_r;
    state_t st_nxt;

    always_comb begin
        logic             setup;
        logic             access;
        logic             wr;
        logic [1:0]       gi;
        logic [5:0]       ofs;
        logic             hit_gen;
        logic [3:0]       sensed;
        logic [3:0]       sel0_eff;
        logic [3:0]       live0;
        logic [7:0]       live1;
        logic [3:0]       stat0;
        logic [7:0]       stat1;
        logic             raw;
        logic [CNT_W-1:0] cnt;
        logic             moved;
        logic [5:0]       ev;
        logic [5:0]       clr;
        logic [3:0]       clr0;
        logic [7:0]       clr1;
        logic             any_irq;
        logic [31:0]      rd;
        logic             err;
        logic [3:0][3:0]  st0_all;
        logic [3:0][7:0]  st1_all;
        setup    = 1'b0;
        access   = 1'b0;
        wr       = 1'b0;
        gi       = 2'h0;
        ofs      = 6'h00;
        hit_gen  = 1'b0;
        sensed   = 4'h0;
        sel0_eff = 4'h0;
        live0    = 4'h0;
        live1    = 8'h00;
        stat0    = 4'h0;
        stat1    = 8'h00;
        raw      = 1'b0;
        cnt      = 16'h0000;
        moved    = 1'b0;
        ev       = 6'h00;
        clr      = 6'h00;
        clr0     = 4'h0;
        clr1     = 8'h00;
        any_irq  = 1'b0;
        rd       = 32'h0000_0000;
        err      = 1'b0;
        st0_all  = '0;
        st1_all  = '0;
        st_nxt   = st_r;

        setup   = psel && !penable;
        access  = psel && penable && st_r.pready;
        wr      = access && pwrite;
        gi      = paddr[7:6];
        ofs     = paddr[5:0];
        hit_gen = (paddr[11:8] == 4'h0);

        for (int g = 0; g < NUM_GEN; g++) begin
            // clear strobes from software writes
            clr  = 6'h00;
            clr0 = 4'h0;
            clr1 = 8'h00;
            if (wr && hit_gen && (gi == 2'(g))) begin
                case (ofs)
                    OFS_MODE:   st_nxt.gen[g].mode   = pwdata[2:0];
                    OFS_SENSE:  st_nxt.gen[g].sense  = pwdata[3:0];
                    OFS_MINPER: st_nxt.gen[g].minper = pwdata[CNT_W-1:0];
                    OFS_SEL0:   st_nxt.gen[g].sel0   = pwdata[3:0];
                    OFS_SEL1:   st_nxt.gen[g].sel1   = pwdata[7:0];
                    OFS_FSTAT0: clr0 = pwdata[3:0];
                    OFS_FSTAT1: clr1 = pwdata[7:0];
                    OFS_INTEN: begin
                        st_nxt.gen[g].irq_en  = pwdata[INTEN_IRQ_LSB +: NUM_EVT];
                        st_nxt.gen[g].trig_en = pwdata[INTEN_TRIG_LSB +: NUM_EVT];
                    end
                    OFS_RIS:    clr = pwdata[5:0];
                    OFS_CMPA:   st_nxt.gen[g].cmpa = pwdata[CNT_W-1:0];
                    OFS_CMPB:   st_nxt.gen[g].cmpb = pwdata[CNT_W-1:0];
                    default:    clr = 6'h00;
                endcase
            end

            // per input sense, one means active low
            sensed = external_fault_input ^ st_r.gen[g].sense;
            // legacy path uses fault input zero only
            // selection applies only in extended mode
            if (st_r.gen[g].mode[MODE_EXTSRC_BIT]) begin
                sel0_eff = st_r.gen[g].sel0;
                live1    = comparator_fault_trigger & st_r.gen[g].sel1;
            end else begin
                sel0_eff = LEGACY_SEL;
                live1    = 8'h00;
            end
            live0 = sensed & sel0_eff;

            // latch holds until cleared, set wins
            st_nxt.gen[g].lat0 = (st_r.gen[g].lat0 & ~clr0) | live0;
            st_nxt.gen[g].lat1 = (st_r.gen[g].lat1 & ~clr1) | live1;

            if (st_r.gen[g].mode[MODE_LATCH_BIT]) begin
                stat0 = st_r.gen[g].lat0 | live0;
                stat1 = st_r.gen[g].lat1 | live1;
            end else begin
                stat0 = live0;
                stat1 = live1;
            end
            st0_all[g] = stat0;
            st1_all[g] = stat1;

            raw = (|stat0) || (|stat1);

            if (raw && st_r.gen[g].mode[MODE_MINPER_BIT]) begin
                st_nxt.gen[g].hold = st_r.gen[g].minper;
            end else if (st_r.gen[g].hold != 16'h0000) begin
                st_nxt.gen[g].hold = st_r.gen[g].hold - 16'h0001;
            end
            st_nxt.gen[g].fault = raw ||
                (st_r.gen[g].mode[MODE_MINPER_BIT] && (st_r.gen[g].hold > 16'h0001));

            // counter events on entry to a match, load event straight from cnt_load
            cnt   = cnt_value[g*CNT_W +: CNT_W];
            moved = (cnt != st_r.gen[g].prev_cnt);
            st_nxt.gen[g].prev_cnt = cnt;
            ev = 6'h00;
            ev[EVT_ZERO] = moved && (cnt == 16'h0000);
            ev[EVT_LOAD] = cnt_load[g];
            ev[EVT_AU]   = moved && (cnt == st_r.gen[g].cmpa) && cnt_up[g];
            ev[EVT_AD]   = moved && (cnt == st_r.gen[g].cmpa) && !cnt_up[g];
            ev[EVT_BU]   = moved && (cnt == st_r.gen[g].cmpb) && cnt_up[g];
            ev[EVT_BD]   = moved && (cnt == st_r.gen[g].cmpb) && !cnt_up[g];

            st_nxt.gen[g].ris = (st_r.gen[g].ris & ~clr) | ev;
            st_nxt.gen[g].trig = ev & st_r.gen[g].trig_en;
            any_irq = any_irq || (|(st_nxt.gen[g].ris & st_nxt.gen[g].irq_en));
        end
        st_nxt.irq = any_irq;

        for (int o = 0; o < NUM_OUT; o++) begin
            if (st_r.gen[o/2].fault && st_r.supp[o]) begin
                st_nxt.pwm[o] = st_r.lvl[o];
            end else begin
                st_nxt.pwm[o] = pwm_in[o];
            end
        end

        if (wr && (paddr == OFS_SUPPRESS)) begin
            st_nxt.supp = pwdata[7:0];
        end
        if (wr && (paddr == OFS_FLT_LEVEL)) begin
            st_nxt.lvl = pwdata[7:0];
        end

        // read data prepared in setup, shown in access
        if (hit_gen) begin
            case (ofs)
                OFS_MODE:   rd = {29'h0, st_r.gen[gi].mode};
                OFS_SENSE:  rd = {28'h0, st_r.gen[gi].sense};
                OFS_MINPER: rd = {16'h0, st_r.gen[gi].minper};
                OFS_SEL0:   rd = {28'h0, st_r.gen[gi].sel0};
                OFS_SEL1:   rd = {24'h0, st_r.gen[gi].sel1};
                OFS_FSTAT0: rd = {28'h0, st0_all[gi]};
                OFS_FSTAT1: rd = {24'h0, st1_all[gi]};
                OFS_INTEN:  rd = {18'h0, st_r.gen[gi].trig_en, 2'h0, st_r.gen[gi].irq_en};
                OFS_RIS:    rd = {26'h0, st_r.gen[gi].ris};
                OFS_MIS:    rd = {26'h0, st_r.gen[gi].ris & st_r.gen[gi].irq_en};
                OFS_CMPA:   rd = {16'h0, st_r.gen[gi].cmpa};
                OFS_CMPB:   rd = {16'h0, st_r.gen[gi].cmpb};
                default:    err = 1'b1;
            endcase
        end else if (paddr == OFS_SUPPRESS) begin
            rd = {24'h0, st_r.supp};
        end else if (paddr == OFS_FLT_LEVEL) begin
            rd = {24'h0, st_r.lvl};
        end else begin
            err = 1'b1;
        end

        if (setup) begin
            st_nxt.pready  = 1'b1;
            st_nxt.pslverr = err;
            st_nxt.prdata  = pwrite ? 32'h0000_0000 : (err ? 32'h0000_0000 : rd);
        end else if (access) begin
            st_nxt.pready  = 1'b0;
            st_nxt.pslverr = 1'b0;
            st_nxt.prdata  = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int g = 0; g < NUM_GEN; g++) begin
                st_r.gen[g].mode     <= RST_MODE;
                st_r.gen[g].sense    <= RST_SENSE;
                st_r.gen[g].minper   <= RST_MINPER;
                st_r.gen[g].sel0     <= RST_SEL0;
                st_r.gen[g].sel1     <= RST_SEL1;
                st_r.gen[g].lat0     <= 4'h0;
                st_r.gen[g].lat1     <= 8'h00;
                st_r.gen[g].hold     <= 16'h0000;
                st_r.gen[g].irq_en   <= 6'h00;
                st_r.gen[g].trig_en  <= 6'h00;
                st_r.gen[g].ris      <= 6'h00;
                st_r.gen[g].cmpa     <= 16'h0000;
                st_r.gen[g].cmpb     <= 16'h0000;
                st_r.gen[g].prev_cnt <= 16'h0000;
                st_r.gen[g].fault    <= 1'b0;
                st_r.gen[g].trig     <= 6'h00;
            end
            st_r.supp    <= 8'h00;
            st_r.lvl     <= 8'h00;
            st_r.pwm     <= 8'h00;
            st_r.pready  <= 1'b0;
            st_r.pslverr <= 1'b0;
            st_r.prdata  <= 32'h0000_0000;
            st_r.irq     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state
    assign prdata  = st_r.prdata;
    assign pready  = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign irq     = st_r.irq;
    assign pwm_out = st_r.pwm;

    for (genvar g = 0; g < NUM_GEN; g++) begin : g_out
        assign gen_fault[g]                       = st_r.gen[g].fault;
        assign event_trigger[g*NUM_EVT +: NUM_EVT] = st_r.gen[g].trig;
    end

endmodule : pwm_fault_event

// ---- test/pwm_fault_event_asserts.sv ----
// concurrent checks on the ports of the pwm fault and event block
`timescale 1ns/10ps
module pwm_fault_event_asserts
    import pwm_fault_event_pkg::*;
(
    // clock, reset and apb
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       irq,
    input wire logic [11:0]                paddr,
    input wire logic [31:0]                prdata,
    // fault, counter and pwm signals
    input wire logic [NUM_EXT-1:0]         external_fault_input,
    input wire logic [NUM_GEN*CNT_W-1:0]   cnt_value,
    input wire logic [NUM_GEN-1:0]         cnt_load,
    input wire logic [NUM_GEN-1:0]         gen_fault,
    input wire logic [NUM_OUT-1:0]         pwm_in,
    input wire logic [NUM_OUT-1:0]         pwm_out,
    input wire logic [NUM_GEN*NUM_EVT-1:0] event_trigger
);
    logic [1:0] age_r;
    logic       untouched_r;

    // edges since reset and whether any write has been made
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_r       <= 2'h0;
            untouched_r <= 1'b1;
        end else begin
            age_r       <= (age_r == 2'h3) ? age_r : age_r + 2'h1;
            untouched_r <= untouched_r && !(psel && penable && pwrite);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no pready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero when idle");
    a_err_unmapped: assert property (pready && paddr[11:8] == 4'h0 && paddr[5:4] == 2'h3 |-> pslverr)
        else $error("unmapped offset not refused");
    a_legacy_fault: assert property (untouched_r && age_r == 2'h3 |->
        gen_fault == {NUM_GEN{$past(external_fault_input[0])}}) else $error("fault not from input zero");
    a_pwm_pass_clean: assert property (age_r == 2'h3 && gen_fault == 4'h0 && $past(gen_fault) == 4'h0 |->
        pwm_out == $past(pwm_in)) else $error("pwm altered without fault");
    a_irq_fall_write: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
        else $error("irq dropped without a write");
    a_event_needs_cause: assert property (age_r == 2'h3 && event_trigger != 24'h0 |->
        $past(cnt_value) != $past(cnt_value, 2) || $past(cnt_load) != 4'h0) else $error("event without cause");
endmodule : pwm_fault_event_asserts

bind pwm_fault_event pwm_fault_event_asserts pwm_fault_event_asserts_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .pready, .pslverr, .irq, .paddr, .prdata, .external_fault_input, .cnt_value, .cnt_load, .gen_fault,
    .pwm_in, .pwm_out, .event_trigger);

// ---- test/testbench.sv ----
// self-checking bench of the pwm fault and event block
`timescale 1ns/10ps
module testbench;
    import pwm_fault_event_pkg::*;
    localparam logic [7:0]  LVL = 8'hA5;
    localparam logic [15:0] STP_V [7] = '{16'h0123, 16'h0456, 16'h0123, 16'h0456, 16'h0000, 16'h0001, 16'h0123};
    localparam logic [6:0]  STP_U = 7'b1100011;
    localparam int          STP_E [7] = '{2, 4, 3, 5, 0, 1, 0};
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic        pready, pslverr, irq, rd_e;
    logic [3:0]  external_fault_input = 4'h0, cnt_up = 4'h0, cnt_load = 4'h0, gen_fault;
    logic [7:0]  comparator_fault_trigger = 8'h00, pwm_in = 8'h00, pwm_out;
    logic [63:0] cnt_value = 64'h0;
    logic [23:0] event_trigger;
    logic [3:0]  sense_m [4], sel0_m [4];
    logic [7:0]  sel1_m [4];
    int          err_total = 0, comparisons = 0;

    pwm_fault_event pwm_fault_event_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .external_fault_input, .comparator_fault_trigger, .cnt_value, .cnt_up, .cnt_load,
        .pwm_in, .pwm_out, .gen_fault, .event_trigger, .irq);

    always #50 pclk = ~pclk;

    task automatic test_done;
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd_q = prdata;
        rd_e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk(32'h0, 32'h1, "apb hang");
    endtask : apb

    function automatic logic [11:0] ga(input int g, input logic [5:0] ofs);
        return GEN_STRIDE * 12'(g) + {6'h00, ofs};
    endfunction : ga

    task automatic wr(input int g, input logic [5:0] ofs, input logic [31:0] d);
        apb(ga(g, ofs), 1'b1, d);
    endtask : wr

    task automatic rd(input int g, input logic [5:0] ofs, input logic [31:0] exp, input string what);
        apb(ga(g, ofs), 1'b0, 32'h0);
        chk(rd_q, exp, what);
    endtask : rd

    function automatic logic exp_fault(input int g);
        return |((external_fault_input ^ sense_m[g]) & sel0_m[g]) | |(comparator_fault_trigger & sel1_m[g]);
    endfunction : exp_fault

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        test_done();
    end

    initial begin
        void'($urandom(32'h7F669EE9));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int g = 0; g < 4; g++) begin
            rd(g, OFS_MODE, 32'h0, "mode reset");
            rd(g, OFS_SEL1, 32'h0, "sel1 reset");
            rd(g, OFS_INTEN, 32'h0, "inten reset");
        end
        external_fault_input <= 4'hE;
        repeat (3) @(posedge pclk);
        chk(32'(gen_fault), 32'h0, "legacy idle");
        external_fault_input <= 4'h1;
        repeat (3) @(posedge pclk);
        chk(32'(gen_fault), 32'hF, "legacy fault");
        apb(OFS_SUPPRESS, 1'b1, 32'(8'hFF));
        apb(OFS_FLT_LEVEL, 1'b1, 32'(LVL));
        for (int g = 0; g < 4; g++) begin
            sense_m[g] = 4'($urandom);
            sel0_m[g]  = (g == 3) ? 4'hF : 4'($urandom);
            sel1_m[g]  = (g == 3) ? 8'h00 : 8'($urandom);
            wr(g, OFS_MODE, 32'h2);
            wr(g, OFS_SENSE, 32'(sense_m[g]));
            wr(g, OFS_SEL0, 32'(sel0_m[g]));
            wr(g, OFS_SEL1, 32'(sel1_m[g]));
        end
        for (int g = 0; g < 4; g++) begin
            rd(g, OFS_SEL0, 32'(sel0_m[g]), "sel0 readback");
            rd(g, OFS_SEL1, 32'(sel1_m[g]), "sel1 readback");
        end
        for (int i = 0; i < 24; i++) begin
            external_fault_input     <= 4'($urandom);
            comparator_fault_trigger <= (i < 2) ? 8'h00 : 8'($urandom);
            pwm_in                   <= 8'($urandom);
            repeat (3) @(posedge pclk);
            for (int g = 0; g < 4; g++) begin
                chk(32'(gen_fault[g]), 32'(exp_fault(g)), "fault");
                chk(32'(pwm_out[2*g+:2]), 32'(exp_fault(g) ? LVL[2*g+:2] : pwm_in[2*g+:2]), "pwm");
            end
        end
        rd(0, OFS_FSTAT1, 32'(comparator_fault_trigger & sel1_m[0]), "live status");
        comparator_fault_trigger <= 8'h00;
        rd(0, OFS_FSTAT1, 32'h0, "live status idle");
        wr(1, OFS_MODE, 32'h3);
        wr(1, OFS_SEL1, 32'hFF);
        wr(1, OFS_FSTAT1, 32'hFF);
        comparator_fault_trigger <= 8'h24;
        repeat (3) @(posedge pclk);
        comparator_fault_trigger <= 8'h00;
        rd(1, OFS_FSTAT1, 32'h24, "latched status");
        wr(1, OFS_FSTAT1, 32'h04);
        rd(1, OFS_FSTAT1, 32'h20, "partial clear");
        wr(2, OFS_CMPA, 32'h0123);
        wr(2, OFS_CMPB, 32'h0456);
        wr(2, OFS_INTEN, 32'h3F3F);
        for (int s = 0; s < 7; s++) begin
            if (s == 6) wr(2, OFS_INTEN, 32'h003F);
            cnt_value[47:32] <= STP_V[s];
            cnt_up[2]        <= STP_U[s];
            cnt_load[2]      <= (s == 5);
            @(posedge pclk);
            cnt_load[2] <= 1'b0;
            @(posedge pclk);
            chk(32'(event_trigger), (s == 6) ? 32'h0 : 32'h1 << (12 + STP_E[s]), "event pulse");
            chk(32'(irq), 32'h1, "irq level");
            @(posedge pclk);
            chk(32'(event_trigger), 32'h0, "pulse width");
        end
        rd(2, OFS_RIS, 32'h3F, "raw status");
        wr(2, OFS_INTEN, 32'h05);
        rd(2, OFS_MIS, 32'h05, "masked status");
        wr(2, OFS_RIS, 32'h05);
        rd(2, OFS_RIS, 32'h3A, "w1c clear");
        chk(32'(irq), 32'h0, "irq masked");
        wr(2, OFS_RIS, 32'h0);
        rd(2, OFS_RIS, 32'h3A, "zero write");
        external_fault_input <= 4'h0;
        wr(3, OFS_SENSE, 32'h0);
        wr(3, OFS_MINPER, 32'h5);
        wr(3, OFS_MODE, 32'h6);
        external_fault_input <= 4'h1;
        @(posedge pclk);
        external_fault_input <= 4'h0;
        repeat (5) begin
            @(posedge pclk);
            chk(32'(gen_fault[3]), 32'h1, "min hold");
        end
        repeat (3) @(posedge pclk);
        chk(32'(gen_fault[3]), 32'h0, "hold end");
        apb(12'h030, 1'b0, 32'h0);
        chk({31'h0, rd_e}, 32'h1, "unmapped error");
        chk(rd_q, 32'h0, "unmapped data");
        test_done();
    end
endmodule : testbench
